// ==== lcdst_regs.sv ====
// LCD supply trim register bank: rail trim, band-gap control, supply-on
`timescale 1ns/1ns
module lcdst_regs
(
	input  wire logic                        clk_i,
	input  wire logic                        nrst_i,
	input  wire logic [lcdst_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [lcdst_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	input  wire logic                        standby_i,
	output logic      [lcdst_pkg::DATA_W-1:0] rdata_o,
	output logic      [3:0]                  coarse_trim_o,
	output logic      [2:0]                  fine_trim_o,
	output logic                             reference_run_o,
	output logic      [2:0]                  reference_trim_o,
	output logic                             supply_en_o
);
	import lcdst_pkg::*;

	// *****************************
	// State
	// *****************************
	typedef struct packed
	{
		logic [3:0] coarse;
		logic [2:0] fine;
		logic       run;
		logic [2:0] ref_trim;
		logic       supply_on;
		logic [7:0] rdata;
	} lcdst_state_t;

	lcdst_state_t state_reg;
	lcdst_state_t state_next;

	// *****************************
	// Elaboration checks
	// *****************************
	// Field slices are fixed below; a changed map must stop here, not in silicon
	if (DATA_W != 8)
	begin : g_chk_data_w
		$error("lcdst_regs expects an 8-bit data bus");
	end

	if (ADDR_W != 4)
	begin : g_chk_addr_w
		$error("lcdst_regs expects a 4-bit address");
	end

	if (COARSE_MSB - COARSE_LSB != 3)
	begin : g_chk_coarse
		$error("coarse trim field must be 4 bits wide");
	end

	if (FINE_MSB - FINE_LSB != 2)
	begin : g_chk_fine
		$error("fine trim field must be 3 bits wide");
	end

	if (REF_TRIM_MSB - REF_TRIM_LSB != 2)
	begin : g_chk_ref_trim
		$error("reference trim field must be 3 bits wide");
	end

	if (RAIL_RSVD_MASK != 8'(1 << RAIL_RSVD_BIT))
	begin : g_chk_rail_rsvd
		$error("rail trim reserved mask must hold only its reserved bit");
	end

	if (BG_RSVD_MASK[REF_RUN_BIT] || !BG_RSVD_MASK[BG_RSVD_MSB] || !BG_RSVD_MASK[BG_RSVD_LSB])
	begin : g_chk_bg_rsvd
		$error("band-gap reserved mask must cover its reserved bits only");
	end

	if (OFS_RAIL_TRIM == OFS_BG_CONTROL || OFS_RAIL_TRIM == OFS_SUPPLY_CTRL || OFS_BG_CONTROL == OFS_SUPPLY_CTRL)
	begin : g_chk_offsets
		$error("register offsets must be distinct");
	end

	if (SUPPLY_ON_BIT >= DATA_W)
	begin : g_chk_supply_bit
		$error("supply-on bit must lie inside the data bus");
	end

	// *****************************
	// Decode
	// *****************************
	// Holes in the map read zero and swallow writes
	function automatic logic is_mapped(input logic [3:0] a);
		return a == OFS_RAIL_TRIM || a == OFS_BG_CONTROL || a == OFS_SUPPLY_CTRL;
	endfunction

	function automatic logic [7:0] read_mux(input lcdst_state_t s, input logic [3:0] a);
		logic [7:0] v;
		v = UNMAPPED_READ;
		unique case (a)
			OFS_RAIL_TRIM:   v = {s.coarse, 1'b0, s.fine} | RAIL_RSVD_MASK;
			OFS_BG_CONTROL:  v = {s.run, 4'h0, s.ref_trim} | BG_RSVD_MASK;
			OFS_SUPPLY_CTRL: v = {7'h00, s.supply_on};
			default:         v = UNMAPPED_READ;
		endcase
		return v;
	endfunction

	// *****************************
	// Next state
	// *****************************
	always_comb
	begin
		state_next = state_reg;
		// Read data valid only the cycle after the strobe
		state_next.rdata = rd_i ? read_mux(state_reg, addr_i) : 8'h00;
		if (wr_i)
		begin
			unique case (addr_i)
				OFS_RAIL_TRIM:
				begin
					state_next.coarse = wdata_i[COARSE_MSB:COARSE_LSB];
					state_next.fine   = wdata_i[FINE_MSB:FINE_LSB];
				end
				OFS_BG_CONTROL:
				begin
					state_next.run      = wdata_i[REF_RUN_BIT];
					state_next.ref_trim = wdata_i[REF_TRIM_MSB:REF_TRIM_LSB];
				end
				OFS_SUPPLY_CTRL: state_next.supply_on = wdata_i[SUPPLY_ON_BIT];
				default:         state_next = state_next;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			state_reg.coarse    <= COARSE_RST;
			state_reg.fine      <= FINE_RST;
			state_reg.run       <= REF_RUN_RST;
			state_reg.ref_trim  <= REF_TRIM_RST;
			state_reg.supply_on <= SUPPLY_ON_RST;
			state_reg.rdata     <= 8'h00;
		end
		else
			state_reg <= state_next;
	end

	// *****************************
	// Outputs
	// *****************************
	// Codes go out raw; the analog side decodes the offsets
	assign coarse_trim_o    = state_reg.coarse;
	assign fine_trim_o      = state_reg.fine;
	assign reference_run_o  = state_reg.run;
	assign reference_trim_o = state_reg.ref_trim;
	assign rdata_o          = state_reg.rdata;

	lcdst_gate u_gate
	(
		.supply_on_i     (state_reg.supply_on),
		.reference_run_i (state_reg.run),
		.standby_i       (standby_i),
		.supply_en_o     (supply_en_o)
	);

	// *****************************
	// Checks
	// *****************************
	sequence s_rail_wr;
		wr_i && addr_i == OFS_RAIL_TRIM;
	endsequence

	property p_coarse_wr;
		@(posedge clk_i) disable iff (!nrst_i)
		s_rail_wr |=> coarse_trim_o == $past(wdata_i[7:4]);
	endproperty
	a_coarse_wr: assert property (p_coarse_wr) else $error("coarse trim not stored");

	property p_coarse_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && addr_i == OFS_RAIL_TRIM) |=> $stable(coarse_trim_o);
	endproperty
	a_coarse_hold: assert property (p_coarse_hold) else $error("coarse trim changed without write");

	property p_rail_rsvd;
		@(posedge clk_i) disable iff (!nrst_i)
		rd_i && addr_i == OFS_RAIL_TRIM |=> rdata_o[3] && rdata_o[7:4] == coarse_trim_o;
	endproperty
	a_rail_rsvd: assert property (p_rail_rsvd) else $error("rail trim readback wrong");

	property p_fine_wr;
		@(posedge clk_i) disable iff (!nrst_i)
		s_rail_wr |=> fine_trim_o == $past(wdata_i[2:0]);
	endproperty
	a_fine_wr: assert property (p_fine_wr) else $error("fine trim not stored");

	property p_fine_read;
		@(posedge clk_i) disable iff (!nrst_i)
		rd_i && addr_i == OFS_RAIL_TRIM |=> rdata_o[2:0] == fine_trim_o;
	endproperty
	a_fine_read: assert property (p_fine_read) else $error("fine trim readback wrong");

	sequence s_bg_wr;
		wr_i && addr_i == OFS_BG_CONTROL;
	endsequence

	property p_run_wr;
		@(posedge clk_i) disable iff (!nrst_i)
		s_bg_wr |=> reference_run_o == $past(wdata_i[7]);
	endproperty
	a_run_wr: assert property (p_run_wr) else $error("run bit not stored");

	property p_bg_rsvd;
		@(posedge clk_i) disable iff (!nrst_i)
		rd_i && addr_i == OFS_BG_CONTROL |=> rdata_o[6:3] == 4'hF && rdata_o[7] == reference_run_o;
	endproperty
	a_bg_rsvd: assert property (p_bg_rsvd) else $error("band-gap readback wrong");

	property p_ref_trim_wr;
		@(posedge clk_i) disable iff (!nrst_i)
		s_bg_wr |=> reference_trim_o == $past(wdata_i[2:0]);
	endproperty
	a_ref_trim_wr: assert property (p_ref_trim_wr) else $error("reference trim not stored");

	property p_ref_trim_read;
		@(posedge clk_i) disable iff (!nrst_i)
		rd_i && addr_i == OFS_BG_CONTROL |=> rdata_o[2:0] == reference_trim_o;
	endproperty
	a_ref_trim_read: assert property (p_ref_trim_read) else $error("reference trim readback wrong");

	property p_supply_gate;
		@(posedge clk_i) disable iff (!nrst_i)
		(!reference_run_o || standby_i) |-> !supply_en_o;
	endproperty
	a_supply_gate: assert property (p_supply_gate) else $error("supply on while halted");

	property p_reset_vals;
		@(posedge clk_i)
		!nrst_i |=> coarse_trim_o == 4'h0 && fine_trim_o == 3'h0 && !reference_run_o && reference_trim_o == 3'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("fields not reset");

	// *****************************
	// Bus and supply checks
	// *****************************
	sequence s_rail_rd;
		rd_i && addr_i == OFS_RAIL_TRIM;
	endsequence

	sequence s_bg_rd;
		rd_i && addr_i == OFS_BG_CONTROL;
	endsequence

	sequence s_supply_wr;
		wr_i && addr_i == OFS_SUPPLY_CTRL;
	endsequence

	sequence s_supply_rd;
		rd_i && addr_i == OFS_SUPPLY_CTRL;
	endsequence

	sequence s_hole_wr;
		wr_i && !is_mapped(addr_i);
	endsequence

	sequence s_hole_rd;
		rd_i && !is_mapped(addr_i);
	endsequence

	property p_fine_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && addr_i == OFS_RAIL_TRIM) |=> $stable(fine_trim_o);
	endproperty
	a_fine_hold: assert property (p_fine_hold) else $error("fine trim changed without write");

	property p_run_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && addr_i == OFS_BG_CONTROL) |=> $stable(reference_run_o);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run bit changed without write");

	property p_ref_trim_hold;
		@(posedge clk_i) disable iff (!nrst_i)
		!(wr_i && addr_i == OFS_BG_CONTROL) |=> $stable(reference_trim_o);
	endproperty
	a_ref_trim_hold: assert property (p_ref_trim_hold) else $error("reference trim changed without write");

	property p_rail_wr_rd;
		@(posedge clk_i) disable iff (!nrst_i)
		s_rail_wr ##1 !wr_i ##1 s_rail_rd |=> rdata_o[7:4] == $past(wdata_i[7:4], 3)
			&& rdata_o[2:0] == $past(wdata_i[2:0], 3);
	endproperty
	a_rail_wr_rd: assert property (p_rail_wr_rd) else $error("rail trim write not read back");

	property p_bg_wr_rd;
		@(posedge clk_i) disable iff (!nrst_i)
		s_bg_wr ##1 !wr_i ##1 s_bg_rd |=> rdata_o[7] == $past(wdata_i[7], 3)
			&& rdata_o[2:0] == $past(wdata_i[2:0], 3);
	endproperty
	a_bg_wr_rd: assert property (p_bg_wr_rd) else $error("band-gap write not read back");

	property p_supply_wr;
		@(posedge clk_i) disable iff (!nrst_i)
		s_supply_wr |=> state_reg.supply_on == $past(wdata_i[SUPPLY_ON_BIT]);
	endproperty
	a_supply_wr: assert property (p_supply_wr) else $error("supply-on bit not stored");

	property p_supply_read;
		@(posedge clk_i) disable iff (!nrst_i)
		s_supply_rd |=> rdata_o == {7'h00, state_reg.supply_on};
	endproperty
	a_supply_read: assert property (p_supply_read) else $error("supply control readback wrong");

	property p_supply_on;
		@(posedge clk_i) disable iff (!nrst_i)
		state_reg.supply_on && reference_run_o && !standby_i |-> supply_en_o;
	endproperty
	a_supply_on: assert property (p_supply_on) else $error("supply off while requested and running");

	property p_hole_wr;
		@(posedge clk_i) disable iff (!nrst_i)
		s_hole_wr |=> $stable(coarse_trim_o) && $stable(fine_trim_o) && $stable(reference_run_o)
			&& $stable(reference_trim_o) && $stable(state_reg.supply_on);
	endproperty
	a_hole_wr: assert property (p_hole_wr) else $error("unmapped write changed a field");

	property p_hole_read;
		@(posedge clk_i) disable iff (!nrst_i)
		s_hole_rd |=> rdata_o == 8'h00;
	endproperty
	a_hole_read: assert property (p_hole_read) else $error("unmapped read not zero");

	property p_rdata_idle;
		@(posedge clk_i) disable iff (!nrst_i)
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read strobe");

	property p_reset_rdata;
		@(posedge clk_i)
		!nrst_i |=> rdata_o == 8'h00 && !supply_en_o && !state_reg.supply_on;
	endproperty
	a_reset_rdata: assert property (p_reset_rdata) else $error("read data or supply not reset");

endmodule

// ==== lcdst_pkg.sv ====
// Package: register map, field layout and reset values of the LCD supply trim block
package lcdst_pkg;

	localparam int         ADDR_W          = 4;
	localparam int         DATA_W          = 8;

	// *****************************
	// Register offsets
	// *****************************
	localparam logic [3:0] OFS_RAIL_TRIM   = 4'h0;
	localparam logic [3:0] OFS_BG_CONTROL  = 4'h1;
	localparam logic [3:0] OFS_SUPPLY_CTRL = 4'h2;

	// *****************************
	// Field positions
	// *****************************
	localparam int         COARSE_MSB      = 7;
	localparam int         COARSE_LSB      = 4;
	localparam int         RAIL_RSVD_BIT   = 3;
	localparam int         FINE_MSB        = 2;
	localparam int         FINE_LSB        = 0;
	localparam int         REF_RUN_BIT     = 7;
	localparam int         BG_RSVD_MSB     = 6;
	localparam int         BG_RSVD_LSB     = 3;
	localparam int         REF_TRIM_MSB    = 2;
	localparam int         REF_TRIM_LSB    = 0;
	localparam int         SUPPLY_ON_BIT   = 0;

	// *****************************
	// Reset and fixed values
	// *****************************
	localparam logic [3:0] COARSE_RST      = 4'h0;
	localparam logic [2:0] FINE_RST        = 3'h0;
	localparam logic [2:0] REF_TRIM_RST    = 3'h0;
	localparam logic       REF_RUN_RST     = 1'b0;
	localparam logic       SUPPLY_ON_RST   = 1'b0;
	localparam logic [7:0] RAIL_RSVD_MASK  = 8'h08;
	localparam logic [7:0] BG_RSVD_MASK    = 8'h78;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

endpackage

// ==== lcdst_gate.sv ====
// Supply-on gating: reference halted or standby forces the supply off
`timescale 1ns/1ns
module lcdst_gate
(
	input  wire logic supply_on_i,
	input  wire logic reference_run_i,
	input  wire logic standby_i,
	output logic      supply_en_o
);
	// Combinational so standby takes effect at once
	assign supply_en_o = supply_on_i & reference_run_i & ~standby_i;
endmodule

// ==== tb_top.sv ====
// Testbench: register access and output checks of the LCD supply trim bank
`timescale 1ns/1ns
module tb_top;
	import lcdst_pkg::*;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        standby_i = 1'b0;
	logic [7:0]  rdata_o;
	logic [3:0]  coarse_trim_o;
	logic [2:0]  fine_trim_o;
	logic        reference_run_o;
	logic [2:0]  reference_trim_o;
	logic        supply_en_o;
	int          err_total = 0;
	int          samples_checked = 0;

	lcdst_regs i_lcdst_regs
	(
		.clk_i            (clk_i),
		.nrst_i           (nrst_i),
		.addr_i           (addr_i),
		.wdata_i          (wdata_i),
		.wr_i             (wr_i),
		.rd_i             (rd_i),
		.standby_i        (standby_i),
		.rdata_o          (rdata_o),
		.coarse_trim_o    (coarse_trim_o),
		.fine_trim_o      (fine_trim_o),
		.reference_run_o  (reference_run_o),
		.reference_trim_o (reference_trim_o),
		.supply_en_o      (supply_en_o)
	);

	initial forever #50 clk_i = ~clk_i;

	// ****************
	// Access tasks
	// ****************
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata_o", e, rdata_o);
	endtask

	task automatic outs(input logic [3:0] c, input logic [2:0] f, input logic r, input logic [2:0] t, input logic s);
		chk("coarse_trim_o", {4'h0, c}, {4'h0, coarse_trim_o});
		chk("fine_trim_o", {5'h00, f}, {5'h00, fine_trim_o});
		chk("reference_run_o", {7'h00, r}, {7'h00, reference_run_o});
		chk("reference_trim_o", {5'h00, t}, {5'h00, reference_trim_o});
		chk("supply_en_o", {7'h00, s}, {7'h00, supply_en_o});
	endtask

	task automatic close_out;
		$display("Checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****************
	// Tests
	// ****************
	initial
	begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		outs(4'h0, 3'h0, 1'b0, 3'h0, 1'b0);
		rd(OFS_RAIL_TRIM, 8'h08);
		rd(OFS_BG_CONTROL, 8'h78);
		rd(OFS_SUPPLY_CTRL, 8'h00);
		// Every coarse code, fine codes cycling, reserved bit written 0
		for (int i = 0; i < 16; i++)
		begin
			wr(OFS_RAIL_TRIM, {i[3:0], 1'b0, i[2:0]});
			outs(i[3:0], i[2:0], 1'b0, 3'h0, 1'b0);
			rd(OFS_RAIL_TRIM, {i[3:0], 1'b1, i[2:0]});
		end
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_BG_CONTROL, {i[0], 4'h0, i[2:0]});
			outs(4'hF, 3'h7, i[0], i[2:0], 1'b0);
			rd(OFS_BG_CONTROL, {i[0], 4'hF, i[2:0]});
		end
		wr(OFS_BG_CONTROL, 8'h80);
		wr(OFS_SUPPLY_CTRL, 8'h01);
		chk("supply_en_o", 8'h01, {7'h00, supply_en_o});
		@(posedge clk_i);
		standby_i <= 1'b1;
		#1;
		chk("supply_en_o", 8'h00, {7'h00, supply_en_o});
		@(posedge clk_i);
		standby_i <= 1'b0;
		#1;
		chk("supply_en_o", 8'h01, {7'h00, supply_en_o});
		wr(OFS_BG_CONTROL, 8'h00);
		chk("supply_en_o", 8'h00, {7'h00, supply_en_o});
		rd(OFS_SUPPLY_CTRL, 8'h01);
		// Unmapped place must neither store nor answer
		wr(OFS_RAIL_TRIM, 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		@(posedge clk_i);
		#1;
		chk("rdata_o", 8'h00, rdata_o);
		rd(OFS_RAIL_TRIM, 8'h08);
		// Reset in mid-run returns every field to its default
		wr(OFS_RAIL_TRIM, 8'hA5);
		wr(OFS_BG_CONTROL, 8'h85);
		outs(4'hA, 3'h5, 1'b1, 3'h5, 1'b1);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		@(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		outs(4'h0, 3'h0, 1'b0, 3'h0, 1'b0);
		rd(OFS_BG_CONTROL, 8'h78);
		rd(OFS_SUPPLY_CTRL, 8'h00);
		close_out();
	end

	// Whole run is under 150 cycles; the limit of 5000 cycles, over thirty times that, means a hang
	initial
	begin
		#500000;
		err_total++;
		close_out();
	end
endmodule
